// File: rtl/tsd_pkg.sv
/*
  Package of the temperature sensor serial slave: constants, carriers and
  the command decode shared by the core and link logic.
  Assumes a 200 MHz core clock and a host-driven shift clock.
*/

package tsd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_MS = 210;
  localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int TEMP_W = 11;
  localparam int CMD_W = 8;
  localparam int CNT_W = 5;
  localparam logic [4:0] TX_BITS = 5'h0e;
  localparam logic [4:0] CNT_LAST = 5'h1f;
  localparam logic [2:0] TEMP_FILL = 3'h7;
  localparam logic [2:0] ID_FILL = 3'h0;
  localparam logic [1:0] IDLE_BITS = 2'h0;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
  // Identification code: arbitrary value
  localparam logic [10:0] ID_CODE_DEF = 11'h2a5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [10:0] TEMP_RESET = 11'h000;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // ----------------------------------------------------------------
  // State carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_prev;
    logic tog_seen;
    logic shut;
    logic first_done;
    logic pending;
    logic [31:0] timer;
    logic [10:0] result;
    logic [15:0] temp_word;
  } tsd_core_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic rx_tog;
  } tsd_rx_s;

  typedef struct packed {
    logic [4:0] cnt;
    logic rx_first;
    logic mid_valid;
    logic mid_shut;
  } tsd_frame_s;

  // Shutdown only on an all-ones command
  function automatic logic is_shutdown(input logic [7:0] cmd);
    return cmd == CMD_SHUTDOWN;
  endfunction

endpackage

// File: rtl/tsd_sync.sv
/*
  Two-stage synchroniser for a group of independent levels.
  Assumes each bit is a level or a toggle that changes slowly.
*/
`timescale 1ns/100ps
`default_nettype none

module tsd_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // Destination clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic [W-1:0] i_d, // Levels from another domain
  output logic [W-1:0] o_q // Synchronised levels
);

  logic [1:0][W-1:0] stage_reg;
  logic [1:0][W-1:0] stage_next;

  // ----------------------------------------------------------------
  // Two flops; only the second stage is read downstream
  // ----------------------------------------------------------------
  always_comb begin
    stage_next = {stage_reg[0], i_d};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign o_q = stage_reg[1];

endmodule
`default_nettype wire

// File: rtl/tsd_tx_edge.sv
/*
  Falling-edge transmit side of the serial link: bit index and drive.
  Assumes the reset input is held while select is high.
*/
`timescale 1ns/100ps
`default_nettype none

module tsd_tx_edge (
  input wire logic i_sclk, // Link shift clock
  input wire logic i_sel_rst_n, // Low while select is high or at reset
  input wire logic [15:0] i_word, // Word to send, may switch at each 32nd rising edge in select
  output logic o_bit, // Current data bit
  output logic o_oe // High while the data line is driven
);

  logic [4:0] fcnt_reg;
  logic [4:0] fcnt_next;
  logic drive;

  // ----------------------------------------------------------------
  // Falling edge count, wraps every 32 clocks
  // ----------------------------------------------------------------
  always_comb begin
    fcnt_next = fcnt_reg + 5'h01;
  end

  always_ff @(negedge i_sclk or negedge i_sel_rst_n) begin
    if (!i_sel_rst_n) begin
      fcnt_reg <= 5'h00;
    end else begin
      fcnt_reg <= fcnt_next;
    end
  end

  // Index zero is on the pin as soon as select falls, before any edge
  assign drive = fcnt_reg < tsd_pkg::TX_BITS;
  assign o_oe = i_sel_rst_n & drive;
  assign o_bit = drive ? i_word[4'hf - fcnt_reg[3:0]] : 1'b0;

endmodule
`default_nettype wire

// File: rtl/tsd_top.sv
/*
  Serial slave of a digital temperature sensor: conversion pacing,
  output word holding, mode control, and the host-clocked shift logic.
  Assumes the converter presents its code on I_TEMP_CODE in the core
  clock domain, and the host drives select and the shift clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tsd_top #(
  parameter int unsigned CONV_CYCLES = tsd_pkg::CONV_CYCLES, // Cycles per conversion
  parameter logic [10:0] ID_CODE = tsd_pkg::ID_CODE_DEF // Arbitrary identity value
) (
  input wire logic I_MCLK, // Core clock, 200 MHz
  input wire logic I_RESETN, // Power-up reset, active low
  input wire logic I_SHIFT_CLOCK_IN, // Host shift clock
  input wire logic I_CS_N, // Chip select, active low
  input wire logic I_SIO, // Data line level as seen at the pin
  output logic O_SIO, // Data line drive value
  output logic O_SIO_OE, // Data line drive enable
  input wire logic [10:0] I_TEMP_CODE, // Converter result, core domain
  output logic O_SHUTDOWN, // High while in shutdown
  output logic O_TEMP_VALID // High once a conversion has finished
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [31:0] TIMER_LAST = 32'(CONV_CYCLES - 1);

  tsd_pkg::tsd_core_s core_reg;
  tsd_pkg::tsd_core_s core_next;
  tsd_pkg::tsd_rx_s rx_reg;
  tsd_pkg::tsd_rx_s rx_next;
  tsd_pkg::tsd_frame_s frame_reg;
  tsd_pkg::tsd_frame_s frame_next;

  logic sel_rst_n;
  logic [1:0] sync_q;
  logic cs_hi;
  logic tog_sync;
  logic cs_rise;
  logic conv_done;
  logic pend;
  logic [10:0] new_temp;
  logic sel_id;
  logic [15:0] tx_word;
  logic [7:0] rx_shifted;

  // ----------------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------------
  // Select level and command toggle share one synchroniser, so both
  // arrive with the same latency; select enters active high so that
  // cleared stages read as deselected and no false release follows reset
  tsd_sync #(
    .W(2)
  ) u_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .i_d({rx_reg.rx_tog, ~I_CS_N}),
    .o_q(sync_q)
  );

  assign cs_hi = ~sync_q[0];
  assign tog_sync = sync_q[1];

  // ----------------------------------------------------------------
  // Core domain: conversion pacing, held word and mode
  // ----------------------------------------------------------------
  always_comb begin
    core_next = core_reg;
    cs_rise = cs_hi & ~core_reg.cs_prev;
    conv_done = ~core_reg.shut & (core_reg.timer == TIMER_LAST);
    core_next.cs_prev = cs_hi;
    new_temp = core_reg.result;

    // Timer is cleared and held at zero in shutdown; reads never restart it
    if (core_reg.shut) begin
      core_next.timer = 32'h0000_0000;
    end else if (conv_done) begin
      core_next.timer = 32'h0000_0000;
    end else begin
      core_next.timer = core_reg.timer + 32'h0000_0001;
    end

    // Capture each finished conversion
    if (conv_done) begin
      new_temp = I_TEMP_CODE;
      core_next.result = I_TEMP_CODE;
      core_next.first_done = 1'b1;
    end

    // Held word changes only while select is high
    pend = core_reg.pending | conv_done;
    if (cs_hi && pend) begin
      core_next.temp_word = {new_temp, tsd_pkg::TEMP_FILL, tsd_pkg::IDLE_BITS};
      core_next.pending = 1'b0;
    end else begin
      core_next.pending = pend;
    end

    // Apply the command at select release, if bits were received
    if (cs_rise && (tog_sync != core_reg.tog_seen)) begin
      core_next.tog_seen = tog_sync;
      core_next.shut = tsd_pkg::is_shutdown(rx_reg.cmd);
      if (core_reg.shut && !tsd_pkg::is_shutdown(rx_reg.cmd)) begin
        core_next.timer = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      core_reg.cs_prev <= 1'b1;
      core_reg.tog_seen <= 1'b0;
      core_reg.shut <= 1'b0;
      core_reg.first_done <= 1'b0;
      core_reg.pending <= 1'b0;
      core_reg.timer <= 32'h0000_0000;
      core_reg.result <= tsd_pkg::TEMP_RESET;
      core_reg.temp_word <= tsd_pkg::WORD_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign O_SHUTDOWN = core_reg.shut;
  assign O_TEMP_VALID = core_reg.first_done;

  // ----------------------------------------------------------------
  // Link domain: receive shift register, never cleared by select
  // ----------------------------------------------------------------
  // Command and toggle must outlive select, so only power-up resets
  // them; the core reads the command once select is seen high again
  assign rx_shifted = {rx_reg.cmd[6:0], I_SIO};

  always_comb begin
    rx_next = rx_reg;
    if (frame_reg.cnt[4]) begin
      rx_next.cmd = rx_shifted;
      if (!frame_reg.rx_first) begin
        rx_next.rx_tog = ~rx_reg.rx_tog;
      end
    end
  end

  always_ff @(posedge I_SHIFT_CLOCK_IN or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rx_reg.cmd <= tsd_pkg::CMD_RESET;
      rx_reg.rx_tog <= 1'b0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: rising edge count, held clear while select is high
  // ----------------------------------------------------------------
  assign sel_rst_n = I_RESETN & ~I_CS_N;

  always_comb begin
    frame_next = frame_reg;
    frame_next.cnt = frame_reg.cnt + 5'h01;
    if (frame_reg.cnt[4]) begin
      frame_next.rx_first = 1'b1;
    end
    // A full receive phase switches the word within the same select
    if (frame_reg.cnt == tsd_pkg::CNT_LAST) begin
      frame_next.mid_valid = 1'b1;
      frame_next.mid_shut = tsd_pkg::is_shutdown(rx_shifted);
    end
  end

  always_ff @(posedge I_SHIFT_CLOCK_IN or negedge sel_rst_n) begin
    if (!sel_rst_n) begin
      frame_reg.cnt <= 5'h00;
      frame_reg.rx_first <= 1'b0;
      frame_reg.mid_valid <= 1'b0;
      frame_reg.mid_shut <= 1'b0;
    end else begin
      frame_reg <= frame_next;
    end
  end

  // ----------------------------------------------------------------
  // Transmit word and falling-edge shifter
  // ----------------------------------------------------------------
  // Core word and mode are quasi-static during select; a conversion
  // landing in the first few core cycles after select falls can still
  // reach the word, well before the host's first sampling edge
  assign sel_id = frame_reg.mid_valid ? frame_reg.mid_shut : core_reg.shut;
  assign tx_word = sel_id ? {ID_CODE, tsd_pkg::ID_FILL, tsd_pkg::IDLE_BITS}
                          : core_reg.temp_word;

  tsd_tx_edge u_tx (
    .i_sclk(I_SHIFT_CLOCK_IN),
    .i_sel_rst_n(sel_rst_n),
    .i_word(tx_word),
    .o_bit(O_SIO),
    .o_oe(O_SIO_OE)
  );

endmodule
`default_nettype wire

// File: tb/tsd_chk.sv
/* Port assertions for the sensor serial slave, bound to tsd_top.
   Assumes select idles high between frames. */
`timescale 1ns/100ps
`default_nettype none
module tsd_chk #(
  parameter int unsigned CONV_CYCLES = 50 // Cycles per conversion
) (
  input wire logic I_MCLK, // Core clock
  input wire logic I_RESETN, // Reset, active low
  input wire logic I_SHIFT_CLOCK_IN, // Link clock
  input wire logic I_CS_N, // Select
  input wire logic I_SIO, // Line level
  input wire logic O_SIO, // Drive value
  input wire logic O_SIO_OE, // Drive enable
  input wire logic O_SHUTDOWN, // Mode
  input wire logic O_TEMP_VALID // Valid flag
);
  logic [4:0] fall_reg; // Falls in select
  logic [4:0] rise_reg; // Rises in select
  logic [7:0] cmd_reg; // Last eight bits in
  logic rx_reg; // Bit taken in this select
  // Edge counts; select high clears them, as in the link logic
  always_ff @(negedge I_SHIFT_CLOCK_IN or posedge I_CS_N) begin
    if (I_CS_N) fall_reg <= 5'h00;
    else fall_reg <= fall_reg + 5'h01;
  end
  always_ff @(posedge I_SHIFT_CLOCK_IN or posedge I_CS_N) begin
    if (I_CS_N) rise_reg <= 5'h00;
    else rise_reg <= rise_reg + 5'h01;
  end
  // Command outlives select, since the mode is applied at release
  always_ff @(posedge I_SHIFT_CLOCK_IN or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cmd_reg <= 8'h00;
      rx_reg <= 1'b0;
    end else if (rise_reg[4]) begin
      cmd_reg <= {cmd_reg[6:0], I_SIO};
      rx_reg <= 1'b1;
    end else if (rise_reg == 5'h00) rx_reg <= 1'b0;
  end
  // Release with and without receive bits
  sequence s_cmd_release;
    $rose(I_CS_N) && rx_reg;
  endsequence
  sequence s_bare_release;
    $rose(I_CS_N) && !rx_reg;
  endsequence
  chk_idle_float: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN) I_CS_N |-> !O_SIO_OE)
    else $error("line driven while deselected");
  chk_drive_window: assert property (
    @(posedge I_SHIFT_CLOCK_IN) disable iff (I_CS_N || !I_RESETN)
    O_SIO_OE == (fall_reg < 5'h0e)) else $error("drive window wrong");
  chk_bit_hold: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN) (O_SIO_OE && !I_CS_N
    && $past(I_CS_N, 6) == 1'b0 && $stable(fall_reg)) |-> $stable(O_SIO))
    else $error("bit changed between falls");
  chk_mode_hold: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN) !I_CS_N [*6] |-> $stable(O_SHUTDOWN))
    else $error("mode changed inside select");
  chk_mode_apply: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN)
    s_cmd_release |-> ##6 O_SHUTDOWN == (cmd_reg == 8'hff))
    else $error("mode not taken from command");
  chk_mode_keep: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN)
    s_bare_release |-> ##6 O_SHUTDOWN == $past(O_SHUTDOWN, 6))
    else $error("mode changed without command");
  chk_reset_mode: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN)
    $rose(I_RESETN) |-> !O_SHUTDOWN && !O_TEMP_VALID) else $error("bad mode after reset");
  chk_valid_sticky: assert property (
    @(posedge I_MCLK) disable iff (!I_RESETN) O_TEMP_VALID |=> O_TEMP_VALID)
    else $error("valid flag dropped");
endmodule
bind tsd_top tsd_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_SHIFT_CLOCK_IN(I_SHIFT_CLOCK_IN),
  .I_CS_N(I_CS_N), .I_SIO(I_SIO), .O_SIO(O_SIO), .O_SIO_OE(O_SIO_OE),
  .O_SHUTDOWN(O_SHUTDOWN), .O_TEMP_VALID(O_TEMP_VALID));
`default_nettype wire

// File: tb/tsd_host.sv
/* Host model: drives select and shift clock, shares the data line.
   Assumes the device drive enable is combinational. */
`timescale 1ns/100ps
`default_nettype none
module tsd_host (
  input wire logic i_oe, // Device drive enable
  input wire logic i_bit, // Device drive value
  output logic o_sclk, // Shift clock, idles low
  output logic o_cs_n, // Select, active low
  output logic o_line // Resolved line level
);
  logic drv = 1'b0; // Host drives the line
  logic dbit = 1'b0; // Host drive value
  logic flip = 1'b0; // Floating line stand-in
  // No pull on the line, so a released line wanders
  always #31.25 flip = ~flip;
  assign o_line = i_oe ? i_bit : (drv ? dbit : flip);
  // Idle: clock low, deselected
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  // Select falls with the clock low; bits out after falls, in at rises
  task automatic xfer(input int n, input logic [63:0] wr, output logic [63:0] rd);
    rd = 64'h0;
    o_cs_n <= 1'b0;
    #100;
    for (int k = 0; k < n; k++) begin
      drv = (k % 32) >= 16;
      dbit = wr[63 - k];
      #31.25 o_sclk = 1'b1;
      rd[63 - k] = o_line;
      #62.5 o_sclk = 1'b0;
      #31.25;
    end
    drv = 1'b0;
    #100 o_cs_n <= 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* Bench top: reset, reads, mode codes and a chained ID read.
   Assumes the host model paces the link at 125 ns. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0; // Core clock
  logic rst_n = 1'b0; // Reset, active low
  logic [10:0] code = 11'h000; // Converter result
  logic sclk, cs_n, line, sio, oe, shut, valid; // Link and status
  logic [63:0] rd; // Bits seen by the host
  logic [10:0] codes [3] = '{11'h258, 11'h724, 11'h7ff}; // +150, -55, -0.25
  localparam logic [10:0] ID_VAL = 11'h15a; // Arbitrary identity value
  int mismatches = 0;
  int compares = 0;
  // Core clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Short conversion keeps the run brief
  tsd_top #(.CONV_CYCLES(50), .ID_CODE(ID_VAL)) DUT (
    .I_MCLK(mclk), .I_RESETN(rst_n), .I_SHIFT_CLOCK_IN(sclk), .I_CS_N(cs_n),
    .I_SIO(line), .O_SIO(sio), .O_SIO_OE(oe), .I_TEMP_CODE(code),
    .O_SHUTDOWN(shut), .O_TEMP_VALID(valid));
  tsd_host host (.i_oe(oe), .i_bit(sio), .o_sclk(sclk), .o_cs_n(cs_n), .o_line(line));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait for the first finished conversion
  task automatic wait_valid;
    for (int i = 0; i < 500; i++) begin
      if (valid === 1'b1) return;
      @(posedge mclk);
    end
    mismatches++;
    report_and_stop;
  endtask
  task automatic t_reset;
    check("shut", {15'h0, shut}, 16'h0000);
    check("valid", {15'h0, valid}, 16'h0000);
    check("oe", {15'h0, oe}, 16'h0000);
  endtask
  // Two's complement code first, then three ones
  task automatic t_temp;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      code <= codes[i];
      wait_valid;
      repeat (120) @(posedge mclk);
      host.xfer(16, 64'h0, rd);
      check("temp", {2'h0, rd[63:50]}, {2'h0, codes[i], 3'h7});
    end
  endtask
  // All ones shuts down; a select cut short keeps the mode
  task automatic t_shut;
    host.xfer(32, {16'h0, 16'h00ff, 32'h0}, rd);
    repeat (10) @(posedge mclk);
    check("shut", {15'h0, shut}, 16'h0001);
    host.xfer(8, 64'h0, rd);
    check("part", {8'h0, rd[63:56]}, {8'h0, ID_VAL[10:3]});
    repeat (10) @(posedge mclk);
    check("kept", {15'h0, shut}, 16'h0001);
    host.xfer(16, 64'h0, rd);
    check("id", {2'h0, rd[63:50]}, {2'h0, ID_VAL, 3'h0});
  endtask
  // Eight normal codes, 0x00 and 0x01 to 0x7f, leave shutdown; only the last byte counts
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      host.xfer(32, {16'h0, 16'h00ff, 32'h0}, rd);
      host.xfer(32, {16'h0, 8'hff, 8'hff >> (8 - i), 32'h0}, rd);
      repeat (10) @(posedge mclk);
      check("run", {15'h0, shut}, 16'h0000);
    end
  endtask
  // Read, shut down, read ID and resume under one select
  task automatic t_chain;
    repeat (120) @(posedge mclk);
    host.xfer(56, {16'h0, 16'hffff, 32'h0}, rd);
    check("chain t", {2'h0, rd[63:50]}, {2'h0, codes[2], 3'h7});
    check("chain id", {2'h0, rd[31:18]}, {2'h0, ID_VAL, 3'h0});
    repeat (10) @(posedge mclk);
    check("resume", {15'h0, shut}, 16'h0000);
  endtask
  // A conversion ending under select reaches the word only at release
  task automatic t_hold;
    fork
      host.xfer(48, 64'h0, rd);
      begin
        repeat (200) @(posedge mclk);
        code <= 11'h0c8;
      end
    join
    check("held", {2'h0, rd[31:18]}, {2'h0, codes[2], 3'h7});
    host.xfer(16, 64'h0, rd);
    check("updated", {2'h0, rd[63:50]}, {2'h0, 11'h0c8, 3'h7});
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    t_reset;
    t_temp;
    t_shut;
    t_codes;
    t_chain;
    t_hold;
    report_and_stop;
  end
endmodule
`default_nettype wire
